// [pkg/bridge_fault_defs.vh]
/*
 * Constants for the bridge fault qualifier: qualifier mode codes, steps and
 * the cycle counts derived from them at a 125 MHz clock.
 * Assumes a single clock of the period given here.
 */
`ifndef BRIDGE_FAULT_DEFS_VH
`define BRIDGE_FAULT_DEFS_VH

`define CLK_PERIOD_PS        8000
`define OC_THR_STEP_MV       200
`define OC_QUAL_STEP_NS      500
`define OC_QUAL_STEP_CYC     ((`OC_QUAL_STEP_NS * 1000) / `CLK_PERIOD_PS)
`define BOOT_TIMEOUT_US      200
`define BOOT_TIMEOUT_CYC     ((`BOOT_TIMEOUT_US * 1000000) / `CLK_PERIOD_PS)
`define QUAL_MODE_DEBOUNCE   1'b0
`define QUAL_MODE_BLANK      1'b1

`endif

// [design/phase_boot_manager.v]
/*
 * One phase of bootstrap charge management and bootstrap undervoltage
 * fault handling. Produces the gated high-side and low-side drives.
 * Assumes every input is already synchronised to clock_i.
 */
`include "bridge_fault_defs.vh"

module phase_boot_manager #(
  parameter TIMEOUT_CYC = `BOOT_TIMEOUT_CYC
) (
  input  wire clock_i,
  input  wire rst_i,
  input  wire hs_cmd_i,
  input  wire ls_cmd_i,
  input  wire boot_above_on_i,
  input  wire boot_below_off_i,
  input  wire boot_uv_i,
  input  wire manager_on_i,
  input  wire uv_mask_i,
  input  wire stop_all_i,
  input  wire global_off_i,
  input  wire clear_state_i,
  input  wire clear_bit_i,
  output reg  hs_drive_o,
  output reg  ls_drive_o,
  output wire fault_event_o,
  output reg  fault_state_o,
  output reg  fault_bit_o
);

  localparam CW = 24;
  localparam integer  TMO_I = TIMEOUT_CYC;
  localparam [CW-1:0] TMO   = TMO_I[CW-1:0];

  reg          charging_q;
  reg [CW-1:0] tmo_q;
  reg          hs_cmd_q;
  wire         hs_rise;
  wire         need_charge;
  wire         tmo_hit;
  wire         direct_uv;

  assign hs_rise = hs_cmd_i & ~hs_cmd_q;
  // [R11] Turn-on needs charge.
  // [R12] Recharge on droop.
  assign need_charge = manager_on_i & hs_cmd_i & ~fault_state_o &
    ((~hs_drive_o & ~boot_above_on_i) | (hs_drive_o & boot_below_off_i));
  // [R13] Recharge timeout.
  assign tmo_hit = charging_q & (tmo_q >= TMO - 1'b1);
  // [R14] Unmanaged immediate fault.
  assign direct_uv = ~manager_on_i & boot_uv_i & hs_cmd_i;
  // [R20] Undervoltage mask.
  assign fault_event_o = ~uv_mask_i & ~fault_state_o & (tmo_hit | direct_uv);

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hs_cmd_q   <= 1'b0;
      charging_q <= 1'b0;
      tmo_q      <= {CW{1'b0}};
    end else begin
      hs_cmd_q <= hs_cmd_i;
      if (need_charge & ~tmo_hit) begin
        charging_q <= 1'b1;
        tmo_q      <= charging_q ? tmo_q + 1'b1 : {CW{1'b0}};
      end else begin
        charging_q <= 1'b0;
        tmo_q      <= {CW{1'b0}};
      end
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fault_state_o <= 1'b0;
      fault_bit_o   <= 1'b0;
    end else begin
      // [R15] Latch fault state.
      // [R18] Latch fault state.
      if (fault_event_o) begin
        fault_state_o <= 1'b1;
      end else if (clear_state_i | (~stop_all_i & hs_rise)) begin
        // [R16] Clear on recommand.
        fault_state_o <= 1'b0;
      end
      // [R17] Sticky bit, set wins.
      if (fault_event_o) begin
        fault_bit_o <= 1'b1;
      end else if (clear_bit_i) begin
        fault_bit_o <= 1'b0;
      end
    end
  end

  // Drives are registered so the gate outputs never glitch.
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hs_drive_o <= 1'b0;
      ls_drive_o <= 1'b0;
    end else if (global_off_i) begin
      hs_drive_o <= 1'b0;
      ls_drive_o <= 1'b0;
    end else if (fault_state_o | fault_event_o) begin
      // [R15] Only high side off.
      // The low side stays under command, so the phase can still brake.
      hs_drive_o <= 1'b0;
      ls_drive_o <= ls_cmd_i & ~hs_cmd_i;
    end else if (charging_q | need_charge) begin
      hs_drive_o <= 1'b0;
      ls_drive_o <= 1'b1;
    end else begin
      hs_drive_o <= hs_cmd_i;
      ls_drive_o <= ls_cmd_i & ~hs_cmd_i;
    end
  end

endmodule

// [design/bridge_fault_qualifier.v]
/*
 * Bridge fault qualifier: overcurrent debounce or blanking qualifier,
 * bootstrap charge management for three phases and the fault actions
 * that follow from the stop-all-on-fault setting.
 * Assumes comparator outputs and phase commands arrive asynchronously and
 * the serial interface delivers a one-cycle diagnostic read pulse.
 */
// Summary of operation
// [R1] Threshold is (code plus one) times 200 mV.
// [R2] Offset shifts amplifier and threshold alike.
// [R3] One bit picks debounce or blanking.
// [R4] Debounce: comparator must hold full period.
// [R5] Blanking: ignore comparator after any switching.
// [R6] New switching restarts the blanking period.
// [R7] Qualifier period is code times 500 ns.
// [R8] Valid overcurrent: live flag, sticky status bit.
// [R9] Overcurrent mask disables overcurrent monitoring.
// [R10] Bootstrap manager on unless disable bit set.
// [R11] High-side waits for charge, low-side recharges.
// [R12] High-side droop starts a recharge cycle.
// [R13] Recharge timeout makes undervoltage fault valid.
// [R14] Unmanaged undervoltage at high-side on: immediate.
// [R15] Stop-all off: latch, flag, bit, one switch.
// [R16] Stop-all off: recommand clears state and flag.
// [R17] Stop-all off: bit clears on read only.
// [R18] Stop-all on: latch, flag, bit, all off.
// [R19] Stop-all on: clear on read with select 0.
// [R20] Undervoltage mask disables all three phases.
// [R21] Timers count the internal reference clock.
`include "bridge_fault_defs.vh"

module bridge_fault_qualifier #(
  parameter BOOT_TIMEOUT = `BOOT_TIMEOUT_CYC,
  parameter QSTEP        = `OC_QUAL_STEP_CYC
) (
  input  wire       clock_i,
  input  wire       rst_i,
  input  wire [3:0] overcurrent_threshold_code_i,
  input  wire [3:0] sense_offset_code_i,
  input  wire       overcurrent_qual_mode_i,
  input  wire [3:0] overcurrent_qual_time_i,
  input  wire       overcurrent_mask_i,
  input  wire       oc_comp_i,
  input  wire       boot_manager_disable_i,
  input  wire       stop_all_on_fault_i,
  input  wire       boot_uv_mask_i,
  input  wire [2:0] hs_cmd_i,
  input  wire [2:0] ls_cmd_i,
  input  wire [2:0] boot_above_on_i,
  input  wire [2:0] boot_below_off_i,
  input  wire [2:0] boot_uv_i,
  input  wire       diag_read_i,
  input  wire       read_clear_sel_i,
  output reg  [8:0] oc_threshold_mv_div10_o,
  output reg  [3:0] oc_threshold_offset_o,
  output wire [2:0] hs_drive_o,
  output wire [2:0] ls_drive_o,
  output reg        fault_flag_o,
  output reg        overcurrent_flag_o,
  output wire       boot_uv_phase_a_o,
  output wire       boot_uv_phase_b_o,
  output wire       boot_uv_phase_c_o
);

  // The top code gives 320 in 10 mV units, so the threshold needs 9 bits.
  localparam integer STEP10_I = `OC_THR_STEP_MV / 10;
  localparam integer QSTEP_I  = QSTEP;
  localparam [8:0]   STEP10   = STEP10_I[8:0];
  localparam [7:0]   QS       = QSTEP_I[7:0];

  // Two-flop synchronisers for all asynchronous pin inputs.
  reg [15:0] s1_q;
  reg [15:0] s2_q;
  wire [15:0] raw = {oc_comp_i, hs_cmd_i, ls_cmd_i, boot_above_on_i,
                     boot_below_off_i, boot_uv_i};
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  wire       comp   = s2_q[15];
  wire [2:0] hs_cmd = s2_q[14:12];
  wire [2:0] ls_cmd = s2_q[11:9];
  wire [2:0] b_on   = s2_q[8:6];
  wire [2:0] b_off  = s2_q[5:3];
  wire [2:0] b_uv   = s2_q[2:0];

  // Threshold DAC code, in units of 10 mV, and the offset that rides on it.
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      oc_threshold_mv_div10_o <= 9'h000;
      oc_threshold_offset_o   <= 4'h0;
    end else begin
      // [R1] Threshold from code.
      oc_threshold_mv_div10_o <= ({5'h00, overcurrent_threshold_code_i} +
                                  9'h001) * STEP10;
      // [R2] Offset on threshold.
      oc_threshold_offset_o <= sense_offset_code_i;
    end
  end

  // Qualifier timer: step prescaler and a step counter.
  reg  [7:0] pre_q;
  reg  [3:0] steps_q;
  reg        running_q;
  reg  [2:0] drv_q;
  wire       switched;
  wire       done;
  wire       debounce = overcurrent_qual_mode_i == `QUAL_MODE_DEBOUNCE;
  reg  [2:0] ls_q;

  assign switched = (hs_drive_o != drv_q) | (ls_drive_o != ls_q);
  // [R7] Period is code times step.
  // [R21] Reference clock timing.
  assign done = running_q & (steps_q >= overcurrent_qual_time_i);

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      drv_q     <= 3'h0;
      ls_q      <= 3'h0;
      pre_q     <= 8'h00;
      steps_q   <= 4'h0;
      running_q <= 1'b0;
    end else begin
      drv_q <= hs_drive_o;
      ls_q  <= ls_drive_o;
      // [R3] Mode select.
      if (debounce) begin
        // [R4] Debounce restart.
        if (!comp || overcurrent_mask_i) begin
          running_q <= 1'b0;
          pre_q     <= 8'h00;
          steps_q   <= 4'h0;
        end else if (!running_q) begin
          running_q <= 1'b1;
          pre_q     <= 8'h00;
          steps_q   <= 4'h0;
        end else if (!done) begin
          if (pre_q >= QS - 8'h01) begin
            pre_q   <= 8'h00;
            steps_q <= steps_q + 4'h1;
          end else begin
            pre_q <= pre_q + 8'h01;
          end
        end
      end else begin
        // [R5] Blanking start.
        // [R6] Retrigger on switching.
        if (switched) begin
          running_q <= 1'b1;
          pre_q     <= 8'h00;
          steps_q   <= 4'h0;
        end else if (done) begin
          running_q <= 1'b0;
        end else if (running_q) begin
          if (pre_q >= QS - 8'h01) begin
            pre_q   <= 8'h00;
            steps_q <= steps_q + 4'h1;
          end else begin
            pre_q <= pre_q + 8'h01;
          end
        end
      end
    end
  end

  // [R9] Mask gates monitoring.
  wire oc_valid = ~overcurrent_mask_i & comp &
                  (debounce ? done : ~running_q & ~switched);

  // Bootstrap handling per phase.
  wire [2:0] ev;
  wire [2:0] st;
  wire [2:0] fb;
  reg        stop_all_q;
  // [R10] Manager enable.
  wire       manager_on = ~boot_manager_disable_i;
  // [R19] Read clear with select.
  wire       rd_clear_all = diag_read_i & ~read_clear_sel_i;
  wire       clr_state = stop_all_on_fault_i & rd_clear_all;
  wire       clr_bit   = stop_all_on_fault_i ? rd_clear_all : diag_read_i;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : ph
      phase_boot_manager #(
        .TIMEOUT_CYC (BOOT_TIMEOUT)
      ) u_ph (
        .clock_i          (clock_i),
        .rst_i            (rst_i),
        .hs_cmd_i         (hs_cmd[g]),
        .ls_cmd_i         (ls_cmd[g]),
        .boot_above_on_i  (b_on[g]),
        .boot_below_off_i (b_off[g]),
        .boot_uv_i        (b_uv[g]),
        .manager_on_i     (manager_on),
        .uv_mask_i        (boot_uv_mask_i),
        .stop_all_i       (stop_all_on_fault_i),
        .global_off_i     (stop_all_q),
        .clear_state_i    (clr_state),
        .clear_bit_i      (clr_bit),
        .hs_drive_o       (hs_drive_o[g]),
        .ls_drive_o       (ls_drive_o[g]),
        .fault_event_o    (ev[g]),
        .fault_state_o    (st[g]),
        .fault_bit_o      (fb[g])
      );
    end
  endgenerate

  // Whole-bridge shutdown, held until the fault state clears.
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stop_all_q <= 1'b0;
    end else if (stop_all_on_fault_i & (|ev)) begin
      // [R18] Disable all switches.
      stop_all_q <= 1'b1;
    end else if (~(|st) | ~stop_all_on_fault_i) begin
      stop_all_q <= 1'b0;
    end
  end

  assign boot_uv_phase_a_o = fb[0];
  assign boot_uv_phase_b_o = fb[1];
  assign boot_uv_phase_c_o = fb[2];

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fault_flag_o       <= 1'b0;
      overcurrent_flag_o <= 1'b0;
    end else begin
      // [R8] Live flag, sticky bit.
      fault_flag_o <= oc_valid | (|ev) | (|st);
      if (oc_valid) begin
        overcurrent_flag_o <= 1'b1;
      end
    end
  end

endmodule

// [sim/fault_checker.sv]
/* Port checker for the bridge fault qualifier.
   Assumes settings stay steady while a fault is pending. */
module fault_checker (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic [3:0] overcurrent_threshold_code_i,
  input wire logic [8:0] oc_threshold_mv_div10_o,
  input wire logic       overcurrent_mask_i,
  input wire logic       overcurrent_flag_o,
  input wire logic       fault_flag_o,
  input wire logic       boot_uv_mask_i,
  input wire logic       stop_all_on_fault_i,
  input wire logic       diag_read_i,
  input wire logic       read_clear_sel_i,
  input wire logic [2:0] hs_drive_o,
  input wire logic [2:0] ls_drive_o,
  input wire logic       boot_uv_phase_a_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  thr_code_a: assert property (
    $stable(overcurrent_threshold_code_i)[*4] |-> oc_threshold_mv_div10_o
    == (overcurrent_threshold_code_i + 9'h001) * 9'h014)
    else $error("threshold value wrong");
  oc_mask_a: assert property (
    overcurrent_mask_i[*4] ##0 !overcurrent_flag_o |=> !overcurrent_flag_o)
    else $error("masked overcurrent flagged");
  oc_sticky_a: assert property (
    overcurrent_flag_o |=> overcurrent_flag_o)
    else $error("overcurrent bit lost");
  oc_fault_a: assert property (
    $rose(overcurrent_flag_o) |-> ##[0:1] fault_flag_o)
    else $error("no fault flag on overcurrent");
  uv_mask_a: assert property (
    boot_uv_mask_i[*4] ##0 !boot_uv_phase_a_o |=> !boot_uv_phase_a_o)
    else $error("masked bootstrap fault set");
  bit_hold_a: assert property (
    boot_uv_phase_a_o && !diag_read_i |=> boot_uv_phase_a_o)
    else $error("bootstrap bit lost without read");
  sel_hold_a: assert property (
    boot_uv_phase_a_o && stop_all_on_fault_i && read_clear_sel_i
    |=> boot_uv_phase_a_o)
    else $error("bootstrap bit cleared with select 1");
  all_off_a: assert property (
    $past(boot_uv_phase_a_o) && boot_uv_phase_a_o && stop_all_on_fault_i
    |-> hs_drive_o == 3'h0 && ls_drive_o == 3'h0)
    else $error("drive on during stop-all fault");
endmodule
bind bridge_fault_qualifier fault_checker fault_checker_i (.*);

// [sim/boot_cap_model.sv]
/* Bootstrap capacitor charge model for the three bridge phases.
   Assumes gated drives from the qualifier; fail_i blocks charging. */
module boot_cap_model (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] hs_i,
  input  wire logic [2:0] ls_i,
  input  wire logic [2:0] fail_i,
  input  wire logic       leak_i,
  output logic      [2:0] above_on_o,
  output logic      [2:0] below_off_o,
  output logic      [2:0] uv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int lvl [3];
  // A leak only drains while the high side is on, as a real gate would.
  always @(posedge clock_i or posedge rst_i)
    for (int p = 0; p < 3; p++) begin
      if (rst_i)
        lvl[p] <= 0;
      else if (ls_i[p] && !fail_i[p])
        lvl[p] <= (lvl[p] > 97) ? 100 : lvl[p] + 3;
      else if (hs_i[p] && leak_i && lvl[p] > 0)
        lvl[p] <= lvl[p] - 1;
    end
  always_comb
    for (int p = 0; p < 3; p++) begin
      above_on_o[p] = lvl[p] > 80;
      below_off_o[p] = lvl[p] < 60;
      uv_o[p] = lvl[p] < 40;
    end
endmodule

// [sim/bridge_fault_qualifier_test.sv]
/* Self-checking bench for the bridge fault qualifier.
   Assumes the bootstrap model stands at the bridge side. */
module bridge_fault_qualifier_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, rst_i = 1, comp = 0, mode = 0, ocm = 0, dis = 0;
  logic sa = 0, uvm = 0, rd = 0, rsel = 0, leak = 0;
  logic [3:0] thr = 0, ofs = 0, qt = 3;
  logic [2:0] hs = 0, ls = 0, fail = 0;
  wire [2:0] hsd, lsd, above, below, uv;
  wire [8:0] thr_o;
  wire [3:0] ofs_o;
  wire ff, ocf, va, vb, vc;
  int n_mismatch = 0, check_count = 0;
  bridge_fault_qualifier #(.BOOT_TIMEOUT(50), .QSTEP(4))
    bridge_fault_qualifier_i (.clock_i(clock_i), .rst_i(rst_i),
    .overcurrent_threshold_code_i(thr), .sense_offset_code_i(ofs),
    .overcurrent_qual_mode_i(mode), .overcurrent_qual_time_i(qt),
    .overcurrent_mask_i(ocm), .oc_comp_i(comp),
    .boot_manager_disable_i(dis), .stop_all_on_fault_i(sa),
    .boot_uv_mask_i(uvm), .hs_cmd_i(hs), .ls_cmd_i(ls),
    .boot_above_on_i(above), .boot_below_off_i(below), .boot_uv_i(uv),
    .diag_read_i(rd), .read_clear_sel_i(rsel),
    .oc_threshold_mv_div10_o(thr_o), .oc_threshold_offset_o(ofs_o),
    .hs_drive_o(hsd), .ls_drive_o(lsd), .fault_flag_o(ff),
    .overcurrent_flag_o(ocf), .boot_uv_phase_a_o(va),
    .boot_uv_phase_b_o(vb), .boot_uv_phase_c_o(vc));
  boot_cap_model boot_cap_model_i (.clock_i(clock_i), .rst_i(rst_i),
    .hs_i(hsd), .ls_i(lsd), .fail_i(fail), .leak_i(leak),
    .above_on_o(above), .below_off_o(below), .uv_o(uv));
  initial forever #4 clock_i = ~clock_i;
  task cyc(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task chk(string s, logic [8:0] e, logic [8:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task do_rst;
    rst_i = 1;
    cyc(16);
    rst_i = 0;
    cyc(2);
  endtask
  task rd_diag(logic s);
    rsel = s;
    rd = 1;
    cyc(1);
    rd = 0;
    cyc(3);
  endtask
  function logic pick(int k);
    case (k)
      0: return hsd[0];
      1: return lsd[0];
      default: return va;
    endcase
  endfunction
  // Bounded wait so a stuck design ends in a mismatch, not a hang.
  task wt(int k);
    for (int i = 0; i < 200 && pick(k) !== 1'b1; i++) cyc(1);
  endtask
  task done(string s);
    $display("test %s done", s);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #50us;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    do_rst();
    for (int c = 0; c < 16; c++) begin
      thr = c[3:0];
      ofs = 4'hF - c[3:0];
      cyc(5);
      chk("thr", (c + 1) * 20, thr_o);
      chk("ofs", 15 - c, ofs_o);
    end
    comp = 1;
    cyc(8);
    comp = 0;
    cyc(4);
    chk("oc short", 0, ocf);
    comp = 1;
    cyc(14);
    chk("oc early", 0, ocf);
    cyc(10);
    chk("oc", 1, ocf);
    chk("ff", 1, ff);
    comp = 0;
    cyc(6);
    chk("ff off", 0, ff);
    chk("oc kept", 1, ocf);
    done("debounce");
    mode = 1;
    do_rst();
    cyc(30);
    ls[2] = 1;
    cyc(4);
    comp = 1;
    cyc(4);
    comp = 0;
    ls[2] = 0;
    cyc(8);
    comp = 1;
    cyc(2);
    comp = 0;
    cyc(4);
    chk("blank", 0, ocf);
    cyc(30);
    comp = 1;
    cyc(3);
    comp = 0;
    cyc(4);
    chk("unblank", 1, ocf);
    done("blanking");
    ocm = 1;
    mode = 0;
    do_rst();
    comp = 1;
    cyc(30);
    comp = 0;
    chk("masked", 0, ocf);
    ocm = 0;
    done("mask");
    do_rst();
    hs[0] = 1;
    cyc(4);
    chk("charge ls", 1, lsd[0]);
    chk("charge hs", 0, hsd[0]);
    wt(0);
    cyc(2);
    chk("hs on", 1, hsd[0]);
    chk("ls off", 0, lsd[0]);
    leak = 1;
    wt(1);
    chk("recharge", 1, lsd[0]);
    leak = 0;
    hs[0] = 0;
    done("manager");
    fail[0] = 1;
    do_rst();
    ls[1] = 1;
    hs[0] = 1;
    cyc(40);
    chk("early", 0, va);
    wt(2);
    chk("timeout", 1, ff);
    chk("hs a", 0, hsd[0]);
    chk("ls b", 1, lsd[1]);
    hs[0] = 0;
    cyc(4);
    hs[0] = 1;
    cyc(4);
    chk("ff clear", 0, ff);
    chk("va kept", 1, va);
    hs[0] = 0;
    fail[0] = 0;
    rd_diag(1);
    chk("va read", 0, va);
    done("single");
    sa = 1;
    dis = 1;
    do_rst();
    hs[0] = 1;
    cyc(6);
    chk("va now", 1, va);
    chk("uv bits", 3'h1, {vc, vb, va});
    chk("all hs", 0, hsd);
    chk("all ls", 0, lsd);
    hs[0] = 0;
    rd_diag(1);
    chk("sel1 va", 1, va);
    chk("sel1 ff", 1, ff);
    rd_diag(0);
    chk("sel0 va", 0, va);
    chk("sel0 ff", 0, ff);
    done("stop all");
    uvm = 1;
    do_rst();
    hs = 3'h7;
    cyc(6);
    chk("hs direct", 3'h7, hsd);
    cyc(60);
    chk("uv masked", 3'h0, {vc, vb, va});
    done("uv mask");
    tally_and_finish();
  end
endmodule
